// *** include/ifr_pkg.sv ***
// types shared by the interrupt request front end modules
// assumes ifr_regs.svh carries the numeric constants
package ifr_pkg;

    // ****************************************************************
    // request lines, one fixed bit position per source
    // ****************************************************************
    typedef struct packed {
        logic [3:0] rsvd_31_28;
        logic timer_3;
        logic timer_2;
        logic [5:0] rsvd_25_20;
        logic two_wire_b;
        logic converter_request;
        logic rsvd_17;
        logic external_pin_request_c;
        logic external_pin_request_b;
        logic external_pin_request_a;
        logic calendar;
        logic clock_lock;
        logic sync_serial_b;
        logic sync_serial_a;
        logic two_wire_a;
        logic rsvd_8;
        logic serial_b;
        logic serial_a;
        logic timer_1;
        logic timer_0;
        logic core_debug_source_b;
        logic core_debug_source_a;
        logic rsvd_1;
        logic watchdog;
    } ifr_src_t;

    // ****************************************************************
    // APB request and answer
    // ****************************************************************
    typedef struct packed {
        logic [31:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } ifr_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } ifr_apb_rsp_t;

endpackage

// *** include/ifr_regs.svh ***
// register map, reset values and fixed read answer of the interrupt request front end
// assumes a 32-bit APB with byte addresses and one aligned word per register
`ifndef IFR_REGS_SVH
`define IFR_REGS_SVH

// ****************************************************************
// register byte addresses
// ****************************************************************
`define IFR_ADDR_RAW 32'hFFFFF008
`define IFR_ADDR_ENABLE 32'hFFFFF010
`define IFR_ADDR_FORCE 32'hFFFFF018
`define IFR_ADDR_RELEASE 32'hFFFFF01C
`define IFR_ADDR_EVT_STAT 32'hFFFFF040
`define IFR_ADDR_EVT_MASK 32'hFFFFF044

// ****************************************************************
// reset values and fixed answers
// ****************************************************************
`define IFR_RST_FORCE 32'h00000000
`define IFR_RST_ENABLE 32'h00000000
`define IFR_RST_EVT 32'h00000000
`define IFR_READ_ZERO 32'h00000000

`endif

// *** verif/ifr_front_end_test.sv ***
// self-checking bench of the interrupt request front end
// assumes zero-wait APB answers and one-cycle output latency
`timescale 1ns/1ps
`include "ifr_regs.svh"
module ifr_front_end_test;
    import ifr_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    ifr_apb_req_t apb_req = '0;
    ifr_apb_rsp_t apb_rsp;
    ifr_src_t periph_req;
    ifr_src_t enabled_req;
    ifr_src_t raw_req;
    ifr_src_t s;
    logic irq;
    logic [31:0] want = 32'h0;
    logic [31:0] seed = 32'hDBB01E19;
    logic [31:0] frc_m = 32'h0;
    logic [31:0] en_m = 32'h0;
    logic [31:0] q;
    logic [31:0] d;
    logic err;
    int fail_count = 0;
    int n_tests = 0;
    int cyc = 0;
    always #12.5 pclk = ~pclk;
    ifr_periph_model u_src (.pclk(pclk), .presetn(presetn), .want(want),
        .periph_req(periph_req));
    ifr_front_end u_dut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
        .apb_rsp(apb_rsp), .periph_req(periph_req), .enabled_req(enabled_req),
        .raw_req(raw_req), .irq(irq));
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function logic [31:0] raw_exp();
        return want | frc_m;
    endfunction
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // request held until pready is seen at a rising edge
    task apb(input logic wr, input logic [31:0] adr, input logic [31:0] dat);
        @(posedge pclk);
        apb_req <= '{adr, 1'b1, 1'b0, wr, dat};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        // no wait count assumed; only the bench timeout ends a hang
        do begin
            @(posedge pclk);
        end while (apb_rsp.pready !== 1'b1);
        q = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask
    task rdc(input string nm, input logic [31:0] adr, input logic [31:0] exp);
        apb(1'b0, adr, 32'h0);
        chk(nm, exp, q);
    endtask
    // two flop stages from want to raw_req
    task put_req(input logic [31:0] v);
        @(posedge pclk);
        want <= v;
        repeat (3) @(posedge pclk);
        @(negedge pclk);
    endtask
    task finish_test();
        $display("counts: %0d checks, %0d mismatches", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            finish_test();
        end
    end
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rdc("force", `IFR_ADDR_FORCE, 32'h0);
        rdc("enable", `IFR_ADDR_ENABLE, 32'h0);
        rdc("raw", `IFR_ADDR_RAW, 32'h0);
        rdc("release", `IFR_ADDR_RELEASE, 32'h0);
        $display("test reset done");
        s = '0;
        s.watchdog = 1'b1;
        s.core_debug_source_a = 1'b1;
        s.core_debug_source_b = 1'b1;
        s.converter_request = 1'b1;
        s.timer_3 = 1'b1;
        put_req(s);
        chk("named bits", 32'h0804000D, raw_req);
        for (int i = 0; i < 32; i++) begin
            put_req(32'h1 << i);
            rdc("raw walk", `IFR_ADDR_RAW, 32'h1 << i);
        end
        put_req(32'h0);
        $display("test positions done");
        d = rnd();
        apb(1'b1, `IFR_ADDR_FORCE, d);
        frc_m = d;
        apb(1'b1, `IFR_ADDR_FORCE, 32'h0);
        rdc("force set", `IFR_ADDR_FORCE, frc_m);
        apb(1'b1, `IFR_ADDR_RELEASE, 32'h0);
        d = rnd();
        apb(1'b1, `IFR_ADDR_RELEASE, d);
        frc_m &= ~d;
        rdc("force clear", `IFR_ADDR_FORCE, frc_m);
        rdc("release", `IFR_ADDR_RELEASE, 32'h0);
        apb(1'b1, `IFR_ADDR_RAW, 32'hFFFFFFFF);
        rdc("raw ro", `IFR_ADDR_RAW, frc_m);
        apb(1'b0, 32'hFFFFF014, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, q);
        $display("test force done");
        for (int i = 0; i < 24; i++) begin
            d = rnd();
            if (i % 3 == 0) begin
                apb(1'b1, `IFR_ADDR_FORCE, d);
                frc_m |= d;
            end else if (i % 3 == 1) begin
                apb(1'b1, `IFR_ADDR_RELEASE, d);
                frc_m &= ~d;
            end else begin
                d = d & rnd() & rnd();
                apb(1'b1, `IFR_ADDR_ENABLE, d);
                en_m |= d;
            end
            put_req(rnd());
            chk("raw_req", raw_exp(), raw_req);
            chk("enabled_req", raw_exp() & en_m, enabled_req);
            rdc("raw", `IFR_ADDR_RAW, raw_exp());
            rdc("enable", `IFR_ADDR_ENABLE, en_m);
        end
        $display("test random done");
        apb(1'b1, `IFR_ADDR_RELEASE, 32'hFFFFFFFF);
        frc_m = 32'h0;
        put_req(32'h0);
        apb(1'b1, `IFR_ADDR_EVT_STAT, 32'hFFFFFFFF);
        apb(1'b1, `IFR_ADDR_EVT_MASK, 32'h00000010);
        rdc("event mask", `IFR_ADDR_EVT_MASK, 32'h00000010);
        put_req(32'h20);
        chk("irq masked", 32'h0, {31'h0, irq});
        rdc("event status", `IFR_ADDR_EVT_STAT, 32'h20);
        put_req(32'h30);
        chk("irq raised", 32'h1, {31'h0, irq});
        apb(1'b1, `IFR_ADDR_EVT_STAT, 32'h10);
        put_req(32'h30);
        chk("irq cleared", 32'h0, {31'h0, irq});
        $display("test interrupt done");
        finish_test();
    end
endmodule // ifr_front_end_test

// *** verif/ifr_periph_model.sv ***
// peripheral request sources feeding the front end
// assumes the bench hands it the wanted request levels
`timescale 1ns/1ps
module ifr_periph_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // wanted levels
    input wire logic [31:0] want,
    // request lines
    output ifr_pkg::ifr_src_t periph_req
);
    import ifr_pkg::*;
    // launched from a flop so levels stay synchronous to pclk
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) periph_req <= '0;
        else periph_req <= ifr_src_t'(want);
    end
endmodule // ifr_periph_model

// *** verif/ifr_properties.sv ***
// checker: bus and request path properties of the front end
// assumes it is bound to ifr_front_end, zero-wait APB
`timescale 1ns/1ps
`include "ifr_regs.svh"
module ifr_properties (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bus
    input wire ifr_pkg::ifr_apb_req_t apb_req,
    input wire ifr_pkg::ifr_apb_rsp_t apb_rsp,
    // requests and interrupt
    input wire ifr_pkg::ifr_src_t periph_req,
    input wire ifr_pkg::ifr_src_t enabled_req,
    input wire ifr_pkg::ifr_src_t raw_req,
    input wire logic irq
);
    import ifr_pkg::*;
    logic [31:0] frc_m;
    logic [31:0] en_m;
    logic [31:0] a;
    logic acc;
    logic rd;
    logic mapped;
    assign a = apb_req.paddr;
    assign acc = apb_req.psel && apb_req.penable;
    assign rd = acc && !apb_req.pwrite;
    assign mapped = a inside {`IFR_ADDR_RAW, `IFR_ADDR_ENABLE, `IFR_ADDR_FORCE,
        `IFR_ADDR_RELEASE, `IFR_ADDR_EVT_STAT, `IFR_ADDR_EVT_MASK};
    // ****************************************************************
    // shadow of force and enable, updated at the access edge
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frc_m <= 32'h0;
            en_m <= 32'h0;
        end else if (acc && apb_req.pwrite && mapped) begin
            if (a == `IFR_ADDR_FORCE) frc_m <= frc_m | apb_req.pwdata;
            if (a == `IFR_ADDR_RELEASE) frc_m <= frc_m & ~apb_req.pwdata;
            if (a == `IFR_ADDR_ENABLE) en_m <= en_m | apb_req.pwdata;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_zero_wait: assert property (acc |-> apb_rsp.pready)
        else $error("pready missing in access");
    a_raw_merge: assert property ($past(presetn) |->
        raw_req == ($past(periph_req) | $past(frc_m))) else $error("raw_req wrong");
    a_enable_gate: assert property ($past(presetn) |-> enabled_req ==
        (($past(periph_req) | $past(frc_m)) & $past(en_m))) else $error("enabled_req wrong");
    a_force_read: assert property (rd && a == `IFR_ADDR_FORCE |->
        apb_rsp.prdata == frc_m) else $error("force read wrong");
    a_enable_read: assert property (rd && a == `IFR_ADDR_ENABLE |->
        apb_rsp.prdata == en_m) else $error("enable read wrong");
    a_release_reads_zero: assert property (rd && a == `IFR_ADDR_RELEASE |->
        apb_rsp.prdata == 32'h0) else $error("release read not zero");
    a_raw_read: assert property (rd && a == `IFR_ADDR_RAW |->
        apb_rsp.prdata == ($past(periph_req) | $past(frc_m))) else $error("raw read wrong");
    a_reset_clear: assert property ($rose(presetn) |->
        raw_req == 32'h0 && enabled_req == 32'h0 && !irq) else $error("reset state wrong");
    a_unmapped_err: assert property (acc |-> apb_rsp.pslverr == !mapped)
        else $error("pslverr wrong");
    c_force_write: cover property (acc && apb_req.pwrite && a == `IFR_ADDR_FORCE);
    c_irq_rise: cover property ($rose(irq));
    c_unmapped: cover property (acc && !mapped);
endmodule // ifr_properties
bind ifr_front_end ifr_properties u_props (.pclk(pclk), .presetn(presetn),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .periph_req(periph_req),
    .enabled_req(enabled_req), .raw_req(raw_req), .irq(irq));

// *** verilog/ifr_apb_slave.sv ***
// APB slave shell: setup-phase read capture, zero-wait access, error on unmapped
// assumes the parent decodes the address into hit and read data combinationally
`timescale 1ns/1ps
module ifr_apb_slave (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bus
    input wire ifr_pkg::ifr_apb_req_t apb_req,
    output ifr_pkg::ifr_apb_rsp_t apb_rsp,
    // decode from parent, write strobe back to it
    input wire logic addr_hit,
    input wire logic [31:0] rd_value,
    output logic wr_pulse
);
    import ifr_pkg::*;
    `include "ifr_regs.svh"

    typedef struct packed {
        logic [31:0] rdata;
        logic err;
    } ifr_slv_state_t;

    ifr_slv_state_t st_reg;
    ifr_slv_state_t st_next;
    logic setup;
    logic access;

    assign setup = apb_req.psel & ~apb_req.penable;
    assign access = apb_req.psel & apb_req.penable;

    // read data sampled in setup so prdata comes from a flop
    always_comb begin
        st_next = st_reg;
        if (setup) begin
            st_next.err = ~addr_hit;
            st_next.rdata = (addr_hit && !apb_req.pwrite) ? rd_value : `IFR_READ_ZERO;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign apb_rsp.pready = access;
    assign apb_rsp.pslverr = access & st_reg.err;
    assign apb_rsp.prdata = st_reg.rdata;
    // writes land at the access edge only, never on an unmapped address
    assign wr_pulse = access & apb_req.pwrite & addr_hit;
endmodule // ifr_apb_slave

// *** verilog/ifr_evt_status.sv ***
// sticky event status with write-one-to-clear, mask and one level interrupt
// assumes events are one-cycle pulses from the parent
`timescale 1ns/1ps
module ifr_evt_status #(
    parameter int WIDTH = 32
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // events and software access
    input wire logic [WIDTH-1:0] evt,
    input wire logic wr_stat,
    input wire logic wr_mask,
    input wire logic [WIDTH-1:0] wdata,
    // state
    output logic [WIDTH-1:0] stat,
    output logic [WIDTH-1:0] mask,
    output logic irq
);
    import ifr_pkg::*;
    `include "ifr_regs.svh"

    typedef struct packed {
        logic [WIDTH-1:0] stat;
        logic [WIDTH-1:0] mask;
        logic irq;
    } ifr_evt_state_t;

    ifr_evt_state_t st_reg;
    ifr_evt_state_t st_next;

    always_comb begin
        st_next = st_reg;
        // set wins over a clear in the same cycle
        if (wr_stat) begin
            st_next.stat = st_reg.stat & ~wdata;
        end
        st_next.stat = st_next.stat | evt;
        if (wr_mask) begin
            st_next.mask = wdata;
        end
        st_next.irq = |(st_next.stat & st_next.mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg.stat <= `IFR_RST_EVT;
            st_reg.mask <= `IFR_RST_EVT;
            st_reg.irq <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign stat = st_reg.stat;
    assign mask = st_reg.mask;
    assign irq = st_reg.irq;
endmodule // ifr_evt_status

// *** verilog/ifr_front_end.sv ***
// interrupt request front end: merges peripheral and forced requests, exposes raw
// state, and gates the merged vector with a set-only enable register
// assumes peripheral requests are synchronous to pclk; APB master on the bus side
//
// Functional notes
// [R01] Each forced bit is ORed with its peripheral request before anything else.
// [R02] Writing a one to a force bit sets it and keeps the request asserted.
// [R03] Writing a zero to a force bit leaves it unchanged.
// [R04] Force, release, raw status and enable all read zero after reset.
// [R05] Writing a one to a release bit clears the matching force bit at once.
// [R06] Writing a zero to a release bit leaves the force bit as it was.
// [R07] The release register is write-only on all 32 bits and acts on ones only.
// [R08] Raw status is read-only and shows the merged state ignoring the enables.
// [R09] A raw bit is one when either source is asserted, zero when neither is.
// [R10] The enable register decides per bit which merged requests go downstream.
// [R11] Every source sits at its own fixed bit from watchdog at 0 up to bit 27.
// [R12] Writing ones sets enable bits, zeros do nothing, reads show the enables.
// [R13] The enabled vector sent downstream is raw AND enable.
`timescale 1ns/1ps
module ifr_front_end (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,

    // APB register bus
    input wire ifr_pkg::ifr_apb_req_t apb_req,
    output ifr_pkg::ifr_apb_rsp_t apb_rsp,

    // peripheral request lines
    input wire ifr_pkg::ifr_src_t periph_req,

    // towards classification
    output ifr_pkg::ifr_src_t enabled_req,
    output ifr_pkg::ifr_src_t raw_req,

    // interrupt
    output logic irq
);
    import ifr_pkg::*;
    `include "ifr_regs.svh"

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [31:0] force_bits;
        logic [31:0] enable_bits;
        logic [31:0] raw_prev;
        logic [31:0] enabled_out;
        logic [31:0] raw_out;
    } ifr_core_state_t;

    ifr_core_state_t st_reg;
    ifr_core_state_t st_next;

    // ****************************************************************
    // wires
    // ****************************************************************
    logic [31:0] hw_bits;
    logic [31:0] raw_bits;
    logic [31:0] rise_bits;
    logic [31:0] rd_value;
    logic [31:0] evt_stat;
    logic [31:0] evt_mask;
    logic addr_hit;
    logic wr_pulse;
    logic wr_evt_stat;
    logic wr_evt_mask;

    // ****************************************************************
    // address decode
    // ****************************************************************
    // full 32-bit compare, so aliases of the map answer with an error
    function automatic logic ifr_is_mapped(input logic [31:0] addr);
        logic hit;
        hit = 1'b0;
        unique case (addr)
            `IFR_ADDR_RAW,
            `IFR_ADDR_ENABLE,
            `IFR_ADDR_FORCE,
            `IFR_ADDR_RELEASE,
            `IFR_ADDR_EVT_STAT,
            `IFR_ADDR_EVT_MASK: begin
                hit = 1'b1;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        return hit;
    endfunction

    function automatic logic ifr_wr_to(
        input logic [31:0] addr,
        input logic [31:0] target,
        input logic strobe
    );
        return strobe && (addr == target);
    endfunction

    assign addr_hit = ifr_is_mapped(apb_req.paddr);

    // ****************************************************************
    // request merge
    // ****************************************************************
    // struct field order fixes each source at its bit position
    assign hw_bits = periph_req; // [R11]

    // forced bits join the raw lines ahead of any gating
    assign raw_bits = hw_bits | st_reg.force_bits; // [R01] [R09]

    // new assertions of any merged request are logged as events
    assign rise_bits = raw_bits & ~st_reg.raw_prev;

    // ****************************************************************
    // read mux
    // ****************************************************************
    always_comb begin
        rd_value = `IFR_READ_ZERO;
        unique case (apb_req.paddr)
            `IFR_ADDR_RAW: begin
                rd_value = raw_bits; // [R08]
            end
            `IFR_ADDR_ENABLE: begin
                rd_value = st_reg.enable_bits; // [R12]
            end
            `IFR_ADDR_FORCE: begin
                rd_value = st_reg.force_bits;
            end
            `IFR_ADDR_RELEASE: begin
                // write-only: nothing is stored, so a read gives zero
                rd_value = `IFR_READ_ZERO; // [R07]
            end
            `IFR_ADDR_EVT_STAT: begin
                rd_value = evt_stat;
            end
            `IFR_ADDR_EVT_MASK: begin
                rd_value = evt_mask;
            end
            default: begin
                rd_value = `IFR_READ_ZERO;
            end
        endcase
    end

    // ****************************************************************
    // register updates
    // ****************************************************************
    always_comb begin
        st_next = st_reg;

        // one-sided writes avoid read-modify-write races with other masters
        if (ifr_wr_to(apb_req.paddr, `IFR_ADDR_FORCE, wr_pulse)) begin
            st_next.force_bits = st_reg.force_bits | apb_req.pwdata; // [R02] [R03]
        end
        if (ifr_wr_to(apb_req.paddr, `IFR_ADDR_RELEASE, wr_pulse)) begin
            st_next.force_bits = st_reg.force_bits & ~apb_req.pwdata; // [R05] [R06] [R07]
        end
        if (ifr_wr_to(apb_req.paddr, `IFR_ADDR_ENABLE, wr_pulse)) begin
            // no clear path here; disabling lives in a later stage
            st_next.enable_bits = st_reg.enable_bits | apb_req.pwdata; // [R12]
        end

        // raw status has no write path at all
        st_next.raw_prev = raw_bits; // [R08]
        st_next.raw_out = raw_bits;
        st_next.enabled_out = raw_bits & st_reg.enable_bits; // [R10] [R13]
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg.force_bits <= `IFR_RST_FORCE; // [R04]
            st_reg.enable_bits <= `IFR_RST_ENABLE; // [R04]
            st_reg.raw_prev <= `IFR_RST_FORCE;
            st_reg.enabled_out <= `IFR_RST_ENABLE;
            st_reg.raw_out <= `IFR_RST_FORCE;
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************************************
    // event status and interrupt
    // ****************************************************************
    assign wr_evt_stat = ifr_wr_to(apb_req.paddr, `IFR_ADDR_EVT_STAT, wr_pulse);
    assign wr_evt_mask = ifr_wr_to(apb_req.paddr, `IFR_ADDR_EVT_MASK, wr_pulse);

    ifr_evt_status #(
        .WIDTH(32)
    ) u_evt (
        .pclk(pclk),
        .presetn(presetn),
        .evt(rise_bits),
        .wr_stat(wr_evt_stat),
        .wr_mask(wr_evt_mask),
        .wdata(apb_req.pwdata),
        .stat(evt_stat),
        .mask(evt_mask),
        .irq(irq)
    );

    // ****************************************************************
    // bus slave
    // ****************************************************************
    ifr_apb_slave u_apb (
        .pclk(pclk),
        .presetn(presetn),
        .apb_req(apb_req),
        .apb_rsp(apb_rsp),
        .addr_hit(addr_hit),
        .rd_value(rd_value),
        .wr_pulse(wr_pulse)
    );

    // ****************************************************************
    // outputs
    // ****************************************************************
    // one cycle behind the lines; the downstream stage is clocked anyway
    assign enabled_req = st_reg.enabled_out; // [R13]
    assign raw_req = st_reg.raw_out;
endmodule // ifr_front_end
